// ---- bcr_bridge_clock_reset.v ----
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "bcr_consts.vh"

module bcr_bridge_clock_reset (
  // system clock and reset
  input wire clk,
  input wire rst_n,
  // reset and strap pins
  input wire p_rst_l,
  input wire bpccStrap,
  // bus clock pins, sampled by clk
  input wire pClk,
  input wire sClk,
  // secondary clock outputs and reset
  output reg [`BCR_NCLK-1:0] sClkO,
  output reg sRstL,
  // nand chain pins, first entry is the arbiter strap, goz_l at index 2
  input wire [`BCR_NAND_W-1:0] nandIn,
  output reg nandOut,
  // primary bus pins
  input wire [31:0] pAdI,
  input wire [3:0] pCbeI,
  input wire pParI,
  input wire [`BCR_CTL_W-1:0] pCtlI,
  output reg [31:0] pAdO,
  output reg pAdOe,
  output reg [3:0] pCbeO,
  output reg pCbeOe,
  output reg pParO,
  output reg pParOe,
  output reg [`BCR_CTL_W-1:0] pCtlO,
  output reg [`BCR_CTL_W-1:0] pCtlOe,
  // secondary bus pins
  input wire [31:0] sAdI,
  input wire [3:0] sCbeI,
  input wire sParI,
  input wire [`BCR_CTL_W-1:0] sCtlI,
  output reg [31:0] sAdO,
  output reg sAdOe,
  output reg [3:0] sCbeO,
  output reg sCbeOe,
  output reg sParO,
  output reg sParOe,
  output reg [`BCR_CTL_W-1:0] sCtlO,
  output reg [`BCR_CTL_W-1:0] sCtlOe,
  // core side, primary
  input wire [31:0] corePAdO,
  input wire corePAdOe,
  input wire [3:0] corePCbeO,
  input wire corePCbeOe,
  input wire corePParO,
  input wire corePParOe,
  input wire [`BCR_CTL_W-1:0] corePCtlO,
  input wire [`BCR_CTL_W-1:0] corePCtlOe,
  output reg [`BCR_BUS_IN_W-1:0] corePIn,
  output reg corePStrobe,
  // core side, secondary
  input wire [31:0] coreSAdO,
  input wire coreSAdOe,
  input wire [3:0] coreSCbeO,
  input wire coreSCbeOe,
  input wire coreSParO,
  input wire coreSParOe,
  input wire [`BCR_CTL_W-1:0] coreSCtlO,
  input wire [`BCR_CTL_W-1:0] coreSCtlOe,
  output reg [`BCR_BUS_IN_W-1:0] coreSIn,
  output reg coreSStrobe,
  // axi4-lite write channels
  input wire [`BCR_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read channels
  input wire [`BCR_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------

  // primary reset acts at once, without the clock
  wire rstAll_n = rst_n & p_rst_l;
  // clock level on top, then ad, cbe, par and the upper control bits
  wire [`BCR_BUS_IN_W-2:0] pInSync;
  wire [`BCR_BUS_IN_W-2:0] sInSync;
  wire [`BCR_NAND_W+2:0] miscSync;
  wire pClkLvl = pInSync[`BCR_BUS_IN_W-2];
  wire sClkLvl = sInSync[`BCR_BUS_IN_W-2];
  wire [`BCR_NAND_W-1:0] nandSync = miscSync[`BCR_NAND_W-1:0];
  wire bpccSync = miscSync[`BCR_NAND_W];
  wire gozN = nandSync[`BCR_GOZ_IDX];

  bcr_sync #(.W(`BCR_BUS_IN_W - 1)) u_sync_p (
    .clk(clk),
    .rst_n(rstAll_n),
    .din({pClk, pAdI, pCbeI, pParI, pCtlI[`BCR_CTL_W-1:1]}),
    .dout(pInSync)
  );

  bcr_sync #(.W(`BCR_BUS_IN_W - 1)) u_sync_s (
    .clk(clk),
    .rst_n(rstAll_n),
    .din({sClk, sAdI, sCbeI, sParI, sCtlI[`BCR_CTL_W-1:1]}),
    .dout(sInSync)
  );

  // spare top bits pad the misc group to a fixed width
  bcr_sync #(.W(`BCR_NAND_W + 3)) u_sync_m (
    .clk(clk),
    .rst_n(rstAll_n),
    .din({2'h0, bpccStrap, nandIn}),
    .dout(miscSync)
  );

  // lowest control bit is synchronised on its own to keep the groups even
  wire [1:0] ctl0Sync;
  bcr_sync #(.W(2)) u_sync_c (
    .clk(clk),
    .rst_n(rstAll_n),
    .din({pCtlI[0], sCtlI[0]}),
    .dout(ctl0Sync)
  );

  // ----------------------------------------
  // bus clock edge detection
  // ----------------------------------------
  reg pClkPrev_q;
  reg sClkPrev_q;
  wire pClkRise = pClkLvl & ~pClkPrev_q;
  wire sClkRise = sClkLvl & ~sClkPrev_q;

  always @(posedge clk or negedge rstAll_n) begin
    if (!rstAll_n) begin
      pClkPrev_q <= 1'b0;
      sClkPrev_q <= 1'b0;
    end else begin
      pClkPrev_q <= pClkLvl;
      sClkPrev_q <= sClkLvl;
    end
  end

  // ----------------------------------------
  // control register and strap
  // ----------------------------------------
  reg [`BCR_CTRL_W-1:0] ctrl_q;
  reg strap_q;
  reg [2:0] strapCnt_q;
  wire secRstBit = ctrl_q[`BCR_SECRST_BIT];
  wire chipRstBit = ctrl_q[`BCR_CHIPRST_BIT];
  wire [`BCR_NCLK-1:0] clkDis = ctrl_q[`BCR_CLKDIS_MSB:`BCR_CLKDIS_LSB];
  wire inD3hot = (ctrl_q[`BCR_PWR_MSB:`BCR_PWR_LSB] == `BCR_D3HOT);
  // strap low means D3hot never reaches the clocks
  wire busB2 = strap_q & inD3hot;

  // the strap is caught once the synchroniser has filled after release;
  // a wait of four cycles or fewer would only ever see the synchroniser's reset value
  always @(posedge clk or negedge rstAll_n) begin
    if (!rstAll_n) begin
      strap_q <= 1'b0;
      strapCnt_q <= 3'h0;
    end else if (strapCnt_q != `BCR_STRAP_WAIT) begin
      strapCnt_q <= strapCnt_q + 3'h1;
      strap_q <= bpccSync;
    end
  end

  // ----------------------------------------
  // secondary clock outputs
  // ----------------------------------------
  reg [`BCR_NCLK-1:0] gateEn_q;

  genvar gi;
  generate
    for (gi = 0; gi < `BCR_NCLK; gi = gi + 1) begin : g_clk
      // enable moves only while the clock is low, so no runt pulse
      always @(posedge clk or negedge rstAll_n) begin
        if (!rstAll_n) begin
          gateEn_q[gi] <= 1'b0;
          sClkO[gi] <= 1'b0;
        end else begin
          if (!pClkLvl) begin
            gateEn_q[gi] <= ~clkDis[gi] & ~busB2;
          end
          sClkO[gi] <= pClkLvl & gateEn_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // secondary reset
  // ----------------------------------------

  // low while primary reset is low, then follows the two bits
  always @(posedge clk or negedge rstAll_n) begin
    if (!rstAll_n) begin
      sRstL <= 1'b0;
    end else begin
      sRstL <= ~(secRstBit | chipRstBit);
    end
  end

  // ----------------------------------------
  // primary bus: sample and launch on primary edge
  // ----------------------------------------
  always @(posedge clk or negedge rstAll_n) begin
    if (!rstAll_n) begin
      corePIn <= {`BCR_BUS_IN_W{1'b0}};
      corePStrobe <= 1'b0;
      pAdO <= 32'h00000000;
      pCbeO <= 4'h0;
      pParO <= 1'b0;
      pCtlO <= {`BCR_CTL_W{1'b0}};
      pAdOe <= 1'b0;
      pCbeOe <= 1'b0;
      pParOe <= 1'b0;
      pCtlOe <= {`BCR_CTL_W{1'b0}};
    end else begin
      corePStrobe <= pClkRise;
      if (pClkRise) begin
        corePIn <= {1'b0, pInSync[`BCR_BUS_IN_W-3:0], ctl0Sync[1]};
        pAdO <= corePAdO;
        pCbeO <= corePCbeO;
        pParO <= corePParO;
        pCtlO <= corePCtlO;
      end
      // tristate control wins at once, not only on the next bus edge
      if (!gozN) begin
        pAdOe <= 1'b0;
        pCbeOe <= 1'b0;
        pParOe <= 1'b0;
        pCtlOe <= {`BCR_CTL_W{1'b0}};
      end else if (pClkRise) begin
        pAdOe <= corePAdOe;
        pCbeOe <= corePCbeOe;
        pParOe <= corePParOe;
        pCtlOe <= corePCtlOe;
      end
    end
  end

  // ----------------------------------------
  // secondary bus: sample and launch on secondary edge
  // ----------------------------------------
  always @(posedge clk or negedge rstAll_n) begin
    if (!rstAll_n) begin
      coreSIn <= {`BCR_BUS_IN_W{1'b0}};
      coreSStrobe <= 1'b0;
      sAdO <= 32'h00000000;
      sCbeO <= 4'h0;
      sParO <= 1'b0;
      sCtlO <= {`BCR_CTL_W{1'b0}};
      sAdOe <= 1'b0;
      sCbeOe <= 1'b0;
      sParOe <= 1'b0;
      sCtlOe <= {`BCR_CTL_W{1'b0}};
    end else begin
      coreSStrobe <= sClkRise;
      if (sClkRise) begin
        coreSIn <= {1'b0, sInSync[`BCR_BUS_IN_W-3:0], ctl0Sync[0]};
        sCtlO <= coreSCtlO;
        if (!sRstL) begin
          sAdO <= 32'h00000000;
          sCbeO <= 4'h0;
          sParO <= 1'b0;
        end else begin
          sAdO <= coreSAdO;
          sCbeO <= coreSCbeO;
          sParO <= coreSParO;
        end
      end
      if (!gozN) begin
        sAdOe <= 1'b0;
        sCbeOe <= 1'b0;
        sParOe <= 1'b0;
        sCtlOe <= {`BCR_CTL_W{1'b0}};
      end else if (sClkRise) begin
        // secondary reset: drive zero data, float controls
        sAdOe <= ~sRstL | coreSAdOe;
        sCbeOe <= ~sRstL | coreSCbeOe;
        sParOe <= ~sRstL | coreSParOe;
        sCtlOe <= sRstL ? coreSCtlOe : {`BCR_CTL_W{1'b0}};
      end
    end
  end

  // ----------------------------------------
  // nand chain
  // ----------------------------------------
  wire [`BCR_NAND_W-1:0] chain;
  assign chain[0] = nandSync[0];
  generate
    for (gi = 1; gi < `BCR_NAND_W; gi = gi + 1) begin : g_nand
      assign chain[gi] = ~(nandSync[gi] & chain[gi-1]);
    end
  endgenerate

  // registered so the test pin never glitches; adds one cycle of lag
  always @(posedge clk or negedge rstAll_n) begin
    if (!rstAll_n) begin
      nandOut <= 1'b0;
    end else begin
      nandOut <= chain[`BCR_NAND_W-1];
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  reg awGot_q;
  reg wGot_q;
  reg [`BCR_ADDR_W-1:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  wire [31:0] statusWord = {23'h000000, ~gozN, strap_q, busB2, gateEn_q, ~sRstL};

  // registers clear only on the primary reset, never on the secondary
  always @(posedge clk or negedge rstAll_n) begin
    if (!rstAll_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BCR_RESP_OKAY;
      awGot_q <= 1'b0;
      wGot_q <= 1'b0;
      awAddr_q <= {`BCR_ADDR_W{1'b0}};
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      ctrl_q <= `BCR_CTRL_RST;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awGot_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!awGot_q & !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wGot_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!wGot_q & !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (awGot_q & wGot_q & !s_axi_bvalid) begin
        awGot_q <= 1'b0;
        wGot_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `BCR_RESP_OKAY;
        if (awAddr_q[`BCR_ADDR_W-1:2] == `BCR_CTRL_OFS >> 2) begin
          if (wStrb_q[0]) begin
            ctrl_q[7:0] <= wData_q[7:0];
          end
          if (wStrb_q[1]) begin
            ctrl_q[`BCR_CTRL_W-1:8] <= wData_q[`BCR_CTRL_W-1:8];
          end
        end else if (awAddr_q[`BCR_ADDR_W-1:2] != `BCR_STAT_OFS >> 2) begin
          s_axi_bresp <= `BCR_RESP_SLVERR;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read side answers the cycle after the address is taken
  always @(posedge clk or negedge rstAll_n) begin
    if (!rstAll_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BCR_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `BCR_RESP_OKAY;
        case (s_axi_araddr[`BCR_ADDR_W-1:2])
          `BCR_CTRL_OFS >> 2: s_axi_rdata <= {22'h000000, ctrl_q};
          `BCR_STAT_OFS >> 2: s_axi_rdata <= statusWord;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BCR_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- bcr_bridge_clock_reset_unused.v ----
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ---- bcr_bus_partner.sv ----
`timescale 1ns/10ps
`default_nettype none

module bcr_bus_partner (
  // clock fed back from the bridge
  input wire logic [4:0] sClkO,
  // clocks seen by the bridge
  output logic pClk,
  output logic sClk
);
  // primary clock runs free; odd offset keeps it unrelated to clk
  initial begin
    pClk = 1'b0;
    #13;
    forever #200 pClk = ~pClk;
  end

  // board loop: the first generated clock times the secondary bus
  assign sClk = sClkO[0];
endmodule

`default_nettype wire

// ---- bcr_consts.vh ----
`ifndef BCR_CONSTS_VH
`define BCR_CONSTS_VH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define BCR_ADDR_W 4
`define BCR_CTRL_OFS 4'h0
`define BCR_STAT_OFS 4'h4

// ----------------------------------------
// control register fields
// ----------------------------------------
`define BCR_SECRST_BIT 0
`define BCR_CHIPRST_BIT 1
`define BCR_CLKDIS_LSB 2
`define BCR_CLKDIS_MSB 6
`define BCR_PWR_LSB 8
`define BCR_PWR_MSB 9
`define BCR_CTRL_W 10
`define BCR_CTRL_RST 10'h000
`define BCR_D3HOT 2'h3

// ----------------------------------------
// status register fields
// ----------------------------------------
`define BCR_ST_SRST_BIT 0
`define BCR_ST_GATE_LSB 1
`define BCR_ST_B2_BIT 6
`define BCR_ST_STRAP_BIT 7
`define BCR_ST_GOZ_BIT 8

// ----------------------------------------
// sizes and bus answers
// ----------------------------------------
`define BCR_NCLK 5
`define BCR_NAND_W 13
`define BCR_GOZ_IDX 2
`define BCR_CTL_W 7
`define BCR_BUS_IN_W 45
`define BCR_STRAP_WAIT 3'h6
`define BCR_RESP_OKAY 2'h0
`define BCR_RESP_SLVERR 2'h2

`endif

// ---- bcr_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bcr_consts.vh"

module bcr_checker (
  // clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic p_rst_l,
  // clocks, reset and test pins
  input wire logic [`BCR_NCLK-1:0] sClkO,
  input wire logic sRstL,
  input wire logic [`BCR_NAND_W-1:0] nandIn,
  input wire logic nandOut,
  // pin drivers
  input wire logic pAdOe,
  input wire logic sAdOe,
  input wire logic [31:0] sAdO,
  input wire logic [`BCR_CTL_W-1:0] sCtlOe,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic [4:0] srCnt_q;
  wire logic rstAll_n = rst_n & p_rst_l;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstAll_n);

  // reference chain over a settled pin set
  function automatic logic nandChain(input logic [`BCR_NAND_W-1:0] v);
    logic c;
    c = v[0];
    for (int k = 1; k < `BCR_NAND_W; k++) c = ~(v[k] & c);
    return c;
  endfunction

  // cycles in secondary reset; pins only settle at a secondary edge, so wait two
  always_ff @(posedge clk or negedge rstAll_n) begin
    if (!rstAll_n) srCnt_q <= 5'h00;
    else if (sRstL) srCnt_q <= 5'h00;
    else if (srCnt_q != 5'h1F) srCnt_q <= srCnt_q + 5'h01;
  end

  sequence wrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence levelHeld(b);
    $stable(b) [*2];
  endsequence

  rst_float_a: assert property (disable iff (!rst_n)
    !p_rst_l |-> !pAdOe && !sRstL && sClkO == '0) else $error("driver left on in reset");
  sec_zero_a: assert property (srCnt_q >= 5'h14 |->
    sCtlOe == '0 && (!sAdOe || sAdO == '0)) else $error("secondary reset pins wrong");
  goz_float_a: assert property ((!nandIn[`BCR_GOZ_IDX]) [*8] |-> !pAdOe && !sAdOe)
    else $error("driver on under tristate");
  nand_chain_a: assert property ($stable(nandIn) [*8] |-> nandOut == nandChain(nandIn))
    else $error("chain output wrong");
  for (genvar i = 0; i < `BCR_NCLK; i++) begin : g_clk
    clk_whole_a: assert property ($changed(sClkO[i]) |=> levelHeld(sClkO[i]))
      else $error("short pulse on secondary clock");
  end
  b_answer_a: assert property (wrTake |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  srst_release_a: assert property ($rose(sRstL) |-> $past(p_rst_l))
    else $error("secondary reset left early");
endmodule

bind bcr_bridge_clock_reset bcr_checker chk (.clk, .rst_n, .p_rst_l, .sClkO, .sRstL,
  .nandIn, .nandOut, .pAdOe, .sAdOe, .sAdO, .sCtlOe, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

`default_nettype wire

// ---- bcr_sync.v ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// three-stage pin synchroniser with agree filter
// ----------------------------------------
module bcr_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // pin side
  input wire [W-1:0] din,
  // filtered level
  output reg [W-1:0] dout
);

  reg [W-1:0] stage1_q;
  reg [W-1:0] stage2_q;
  reg [W-1:0] stage3_q;

  // stage1 feeds only stage2, so metastability never reaches the filter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= INIT;
      stage2_q <= INIT;
      stage3_q <= INIT;
      dout <= INIT;
    end else begin
      stage1_q <= din;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      // a bit changes only once stages two and three agree
      dout <= (stage2_q & stage3_q) | (dout & (stage2_q | stage3_q));
    end
  end

endmodule

`default_nettype wire

// ---- tb_bcr_bridge_clock_reset.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bcr_consts.vh"

module tb_bcr_bridge_clock_reset;
  localparam logic [1:0] okR = `BCR_RESP_OKAY;
  localparam logic [1:0] errR = `BCR_RESP_SLVERR;
  localparam logic [3:0] ctrl = `BCR_CTRL_OFS;
  logic clk = 1'b0;
  logic rst_n, p_rst_l, bpccStrap, pClk, sClk, nandOut, sRstL, srstD;
  logic [4:0] sClkO, m;
  logic [7:0] n0;
  logic [12:0] nandIn;
  logic [63:0] rp, rs, rc;
  logic [31:0] pAdI, sAdI, pAdO, sAdO, corePAdO, coreSAdO, s_axi_wdata, s_axi_rdata;
  logic [3:0] pCbeI, sCbeI, pCbeO, sCbeO, corePCbeO, coreSCbeO, s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [6:0] pCtlI, sCtlI, pCtlO, sCtlO, pCtlOe, sCtlOe, corePCtlO, coreSCtlO;
  logic [6:0] corePCtlOe, coreSCtlOe;
  logic pParI, sParI, pParO, sParO, pAdOe, sAdOe, pCbeOe, sCbeOe, pParOe, sParOe;
  logic corePAdOe, coreSAdOe, corePCbeOe, coreSCbeOe, corePParO, coreSParO;
  logic corePParOe, coreSParOe, corePStrobe, coreSStrobe;
  logic [44:0] corePIn, coreSIn;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  integer seed = 40;
  integer bad_count = 0;
  integer checked = 0;
  logic [1:0] wq[$];
  logic [33:0] rq[$];

  // ----------------------------------------
  // design, far side and clock
  // ----------------------------------------
  bcr_bridge_clock_reset dut (.*);
  bcr_bus_partner far (.sClkO(sClkO), .pClk(pClk), .sClk(sClk));
  always #25 clk = ~clk;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("Error %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic hang();
    bad_count = bad_count + 1;
    $display("Error %0t: no answer", $time);
    stop_test();
  endtask

  // core drive values change only at reset, so pin data stay traceable
  task automatic newCore();
    rc = {$random(seed), $random(seed)};
    {corePAdO, corePCbeO, corePParO, corePCtlO, corePCtlOe, corePCbeOe, corePParOe} <= rc[52:0];
    rc = {$random(seed), $random(seed)};
    {coreSAdO, coreSCbeO, coreSParO, coreSCtlO, coreSCtlOe, coreSCbeOe, coreSParOe} <= rc[52:0];
    {corePAdOe, coreSAdOe} <= 2'h3;
  endtask

  task automatic axWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    wq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 100) hang();
  endtask

  task automatic axRead(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    rq.push_back({d, r});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 100) hang();
  endtask

  // rising edges of each generated clock over five primary periods
  task automatic rises();
    logic [4:0] prev;
    repeat (16) @(posedge clk);
    {m, n0, prev} = {5'h00, 8'h00, sClkO};
    repeat (40) begin
      @(posedge clk);
      m = m | (sClkO & ~prev);
      n0 = n0 + {7'h00, sClkO[0] & ~prev[0]};
      prev = sClkO;
    end
  endtask

  function automatic logic nandRef(input logic [12:0] v);
    logic c;
    c = v[0];
    for (int k = 1; k < 13; k++) c = ~(v[k] & c);
    return c;
  endfunction

  // ----------------------------------------
  // watcher: answers against notes, bus samples against pins
  // ----------------------------------------
  always @(posedge clk) begin
    srstD <= sRstL;
    if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, wq.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rdata, s_axi_rresp}, rq.pop_front());
    if (corePStrobe) begin
      check(corePIn[43:0], {pAdI, pCbeI, pParI, pCtlI});
      if (pAdOe) check({pAdO, pCtlOe}, {corePAdO, corePCtlOe});
      rp = {$random(seed), $random(seed)};
      {pAdI, pCbeI, pParI, pCtlI} <= rp[43:0];
    end
    if (coreSStrobe) begin
      check(coreSIn[43:0], {sAdI, sCbeI, sParI, sCtlI});
      if (sRstL && srstD && sAdOe) check(sAdO, coreSAdO);
      rs = {$random(seed), $random(seed)};
      {sAdI, sCbeI, sParI, sCtlI} <= rs[43:0];
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    hang();
  end

  initial begin
    {rst_n, p_rst_l, bpccStrap, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h10;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {pAdI, pCbeI, pParI, pCtlI, sAdI, sCbeI, sParI, sCtlI} = '0;
    s_axi_wstrb = 4'hF;
    nandIn = 13'h1FFF;
    newCore();
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    // reset value, unmapped and read-only places
    axRead(ctrl, 32'h0, okR);
    axRead(4'hC, 32'h0, errR);
    axWrite(4'h8, 32'h3FF, errR);
    axWrite(`BCR_STAT_OFS, 32'h3FF, okR);
    axRead(ctrl, 32'h0, okR);
    // secondary reset from each bit, registers still reachable
    axWrite(ctrl, 32'h1, okR);
    repeat (30) @(posedge clk);
    check(sRstL, 1'b0);
    axRead(ctrl, 32'h1, okR);
    axWrite(ctrl, 32'h2, okR);
    repeat (3) @(posedge clk);
    check(sRstL, 1'b0);
    axWrite(ctrl, 32'h0, okR);
    repeat (3) @(posedge clk);
    check(sRstL, 1'b1);
    for (int i = 0; i < 5; i++) begin
      axWrite(ctrl, 32'h1 << (i + 2), okR);
      rises();
      check(m, 5'h1F & ~(5'h01 << i));
    end
    axWrite(ctrl, 32'h300, okR);
    rises();
    check({m, n0}, {5'h1F, 8'h05});
    // chain test runs with every driver floated
    for (int i = 0; i < 6; i++) begin
      nandIn <= 13'($random(seed)) & 13'h1FFB;
      repeat (10) @(posedge clk);
      check({nandOut, pAdOe, sAdOe, pCtlOe, sCtlOe}, {nandRef(nandIn), 16'h0000});
    end
    nandIn <= 13'h1FFF;
    // second reset in mid-run, strap now high
    {bpccStrap, p_rst_l} <= 2'h2;
    newCore();
    repeat (3) @(posedge clk);
    check({sRstL, pAdOe, pCtlOe}, 9'h000);
    p_rst_l <= 1'b1;
    repeat (10) @(posedge clk);
    axRead(ctrl, 32'h0, okR);
    axWrite(ctrl, 32'h300, okR);
    rises();
    check({m, sClkO}, 10'h000);
    axWrite(ctrl, 32'h0, okR);
    rises();
    check({m, n0}, {5'h1F, 8'h05});
    stop_test();
  end
endmodule

`default_nettype wire
